// ---- logic/kmsd_defs.svh ----
`ifndef KMSD_DEFS_SVH
`define KMSD_DEFS_SVH
`define KMSD_ADDR_W 8
`define KMSD_ADDR_MASK_A 8'h08
`define KMSD_ADDR_MASK_B 8'h09
`define KMSD_ADDR_MASK_C 8'h0a
`define KMSD_ADDR_MASK_D 8'h0b
`define KMSD_ADDR_DEB_A 8'h08
`define KMSD_ADDR_DEB_B 8'h09
`define KMSD_ADDR_DEB_C 8'h0a
`define KMSD_ADDR_DEB_D 8'h0b
`define KMSD_ADDR_PRS_A 8'h0c
`define KMSD_ADDR_PRS_B 8'h0d
`define KMSD_ADDR_PRS_C 8'h0e
`define KMSD_ADDR_PRS_D 8'h0f
`define KMSD_RST_MASK 8'h00
`define KMSD_RST_STATUS 8'h00
`define KMSD_CLK_HZ 200000000
`define KMSD_SLOT_US 200
`define KMSD_SLOT_CYC ((`KMSD_CLK_HZ / 1000000) * `KMSD_SLOT_US)
`define KMSD_MUX_US 1600
`define KMSD_PASS_US 25600
`define KMSD_DRIVERS 8
`define KMSD_LINES 4
`endif

// ---- logic/kmsd_pkg.sv ----
package kmsd_pkg;
    typedef logic [7:0] kmsd_byte_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } kmsd_req_s;
    typedef enum logic [1:0] {
        KMSD_IDLE = 2'b00,
        KMSD_SAMPLE = 2'b01,
        KMSD_UPDATE = 2'b10
    } kmsd_scan_e;
endpackage

// ---- logic/kmsd_sync.sv ----
`timescale 1ns/1ps
module kmsd_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '1;
            q_o <= '1;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// ---- logic/kmsd_slot_timer.sv ----
`timescale 1ns/1ps
`include "kmsd_defs.svh"
module kmsd_slot_timer #(
    parameter int SLOT_CYC = `KMSD_SLOT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o
);
    logic [31:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 32'h0;
            tick_o <= 1'b0;
        end else if (cnt_q == 32'(SLOT_CYC - 1)) begin
            cnt_q <= 32'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick_o <= 1'b0;
        end
    end
endmodule

// ---- logic/kmsd_key_scan.sv ----
`timescale 1ns/1ps
`include "kmsd_defs.svh"
// Contract
// - Scan loops; full pass over up to 32 keys (drivers 0 to scan limit)
// - Sample four lines in one slot per multiplex cycle
// - Debounce needs two consecutive pressed samples
// - Any key combination detected, no blocking
// - Write-only enables gate per-key interrupt
// - Scanning runs regardless of enable bits
// - Debounced bit sticky until register read
// - Debounced read returns data, then clears
// - New debounces OR into unread contents
// - Any debounced read drops interrupt unless a new enabled debounce lands in the same cycle
// - Held key debounces once until released
// - Pressed bits show latest scan result
// - Unused register bits read zero
// - Pressed read clears nothing
// - Fifth pin is interrupt when scanning
// - Drivers go low in turn per slot
// - Only drivers within scan limit scanned
module kmsd_key_scan #(
    parameter int SLOT_CYC = `KMSD_SLOT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scan_en_i,
    input wire logic [2:0] scan_limit_i,
    input wire logic [3:0] line_en_i,
    input wire logic [3:0] key_n_i,
    input wire kmsd_pkg::kmsd_req_s req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [7:0] cathode_n_o,
    output logic irq_n_o,
    output logic irq_oe_o
);
    // ------------------------------------------------------------
    // Slot timing and sampling
    // ------------------------------------------------------------
    logic tick;
    logic [3:0] key_n_s;
    logic [2:0] slot_q;
    logic [2:0] pick_q;
    logic [31:0] key_mask_q;
    logic [31:0] key_deb_q;
    logic [31:0] key_prs_q;
    logic [31:0] key_prev_q;
    logic [31:0] key_lock_q;
    logic irq_q;
    logic [31:0] deb_clr;
    logic [31:0] new_deb;
    logic [31:0] slot_hit;
    logic [31:0] slot_now;
    logic deb_rd;

    kmsd_slot_timer #(.SLOT_CYC(SLOT_CYC)) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // Key lines are off-chip and unsynchronised
    kmsd_sync #(.WIDTH(4)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(key_n_i),
        .q_o(key_n_s)
    );

    // Drivers wrap at the scan limit so unused digits are never read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_q <= 3'h0;
        end else if (tick) begin
            slot_q <= (slot_q >= scan_limit_i) ? 3'h0 : slot_q + 3'h1;
        end
    end

    // One driver's keys per multiplex cycle, so a full pass spans one cycle per digit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pick_q <= 3'h0;
        end else if (tick && (slot_q >= scan_limit_i)) begin
            pick_q <= (pick_q >= scan_limit_i) ? 3'h0 : pick_q + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cathode_n_o <= 8'hff;
        end else begin
            cathode_n_o <= ~(8'h01 << slot_q);
        end
    end

    // ------------------------------------------------------------
    // Per-key debounce
    // ------------------------------------------------------------
    // Sample lands at the end of the slot, after the line has settled
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_key
            localparam int LINE = g / 8;
            localparam int DRV = g % 8;
            assign slot_hit[g] = tick && scan_en_i && line_en_i[LINE]
                && (slot_q == 3'(DRV)) && (pick_q == 3'(DRV));
            assign slot_now[g] = ~key_n_s[LINE];
            assign new_deb[g] = slot_hit[g] && slot_now[g] && key_prev_q[g] && !key_lock_q[g];
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_prev_q <= 32'h0;
            key_prs_q <= 32'h0;
            key_lock_q <= 32'h0;
        end else begin
            for (int i = 0; i < 32; i++) begin
                if (slot_hit[i]) begin
                    key_prev_q[i] <= slot_now[i];
                    key_prs_q[i] <= slot_now[i];
                    if (!slot_now[i]) begin
                        key_lock_q[i] <= 1'b0;
                    end else if (new_deb[i]) begin
                        key_lock_q[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    always_comb begin
        deb_clr = 32'h0;
        deb_rd = 1'b0;
        if (req_i.rd) begin
            case (req_i.addr)
                `KMSD_ADDR_DEB_A: begin deb_clr[7:0] = 8'hff; deb_rd = 1'b1; end
                `KMSD_ADDR_DEB_B: begin deb_clr[15:8] = 8'hff; deb_rd = 1'b1; end
                `KMSD_ADDR_DEB_C: begin deb_clr[23:16] = 8'hff; deb_rd = 1'b1; end
                `KMSD_ADDR_DEB_D: begin deb_clr[31:24] = 8'hff; deb_rd = 1'b1; end
                default: deb_clr = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_mask_q <= {4{`KMSD_RST_MASK}};
        end else if (req_i.wr) begin
            case (req_i.addr)
                `KMSD_ADDR_MASK_A: key_mask_q[7:0] <= req_i.wdata;
                `KMSD_ADDR_MASK_B: key_mask_q[15:8] <= req_i.wdata;
                `KMSD_ADDR_MASK_C: key_mask_q[23:16] <= req_i.wdata;
                `KMSD_ADDR_MASK_D: key_mask_q[31:24] <= req_i.wdata;
                default: key_mask_q <= key_mask_q;
            endcase
        end
    end

    // New debounce in the read cycle survives the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_deb_q <= {4{`KMSD_RST_STATUS}};
        end else begin
            key_deb_q <= (key_deb_q & ~deb_clr) | new_deb;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else if (|(new_deb & key_mask_q)) begin
            irq_q <= 1'b1;
        end else if (deb_rd) begin
            irq_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            case (req_i.addr)
                `KMSD_ADDR_DEB_A: rdata_o <= key_deb_q[7:0];
                `KMSD_ADDR_DEB_B: rdata_o <= key_deb_q[15:8];
                `KMSD_ADDR_DEB_C: rdata_o <= key_deb_q[23:16];
                `KMSD_ADDR_DEB_D: rdata_o <= key_deb_q[31:24];
                `KMSD_ADDR_PRS_A: rdata_o <= key_prs_q[7:0];
                `KMSD_ADDR_PRS_B: rdata_o <= key_prs_q[15:8];
                `KMSD_ADDR_PRS_C: rdata_o <= key_prs_q[23:16];
                `KMSD_ADDR_PRS_D: rdata_o <= key_prs_q[31:24];
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    // Open-drain, active low; pin released when scanning is off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_n_o <= 1'b1;
            irq_oe_o <= 1'b0;
        end else begin
            irq_n_o <= ~irq_q;
            irq_oe_o <= scan_en_i & irq_q;
        end
    end
endmodule

// ---- tb/kmsd_key_scan_chk.sv ----
`timescale 1ns/1ps
module kmsd_key_scan_chk #(
    parameter int SLOT_CYC = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scan_en_i,
    input wire logic [2:0] scan_limit_i,
    input wire logic [3:0] line_en_i,
    input wire logic [3:0] key_n_i,
    input wire kmsd_pkg::kmsd_req_s req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [7:0] cathode_n_o,
    input wire logic irq_n_o,
    input wire logic irq_oe_o
);
// ----
// Slot length counter
// ----
// First two changes after reset are skipped: the first slot runs one cycle long
int cnt_q;
logic [1:0] seen_q;
logic [7:0] prev_q;
always_ff @(posedge clk_i) begin
    prev_q <= cathode_n_o;
    if (rst_i || prev_q != cathode_n_o) begin
        cnt_q <= 0;
    end else begin
        cnt_q <= cnt_q + 1;
    end
    if (rst_i) begin
        seen_q <= 2'h0;
    end else if (prev_q != cathode_n_o && seen_q != 2'h2) begin
        seen_q <= seen_q + 2'h1;
    end
end
// ----
// Properties
// ----
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
read_answer_a: assert property (req_i.rd |=> rvalid_o)
    else $error("read not answered");
one_driver_a: assert property ($onehot0(~cathode_n_o))
    else $error("two drivers low");
scan_limit_a: assert property (({1'b0, ~cathode_n_o} >> scan_limit_i) <= 9'h1)
    else $error("driver past limit");
irq_release_a: assert property ((req_i.rd && req_i.addr[7:2] == 6'h02) |-> ##2 irq_n_o)
    else $error("irq kept after read");
irq_pin_a: assert property (irq_oe_o == ($past(scan_en_i) && !irq_n_o))
    else $error("irq enable wrong");
pressed_read_a: assert property ((req_i.rd && req_i.addr[7:2] == 6'h03 && !irq_n_o
    && !$past(req_i.rd && req_i.addr[7:2] == 6'h02)) |=> !irq_n_o)
    else $error("pressed read dropped irq");
unmapped_zero_a: assert property ((req_i.rd && req_i.addr[7:3] != 5'h01) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
slot_period_a: assert property ((seen_q == 2'h2 && prev_q != cathode_n_o) |-> cnt_q == SLOT_CYC - 1)
    else $error("slot length wrong");
endmodule
bind kmsd_key_scan kmsd_key_scan_chk #(.SLOT_CYC(SLOT_CYC)) kmsd_key_scan_chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .scan_en_i(scan_en_i), .scan_limit_i(scan_limit_i),
    .line_en_i(line_en_i), .key_n_i(key_n_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .cathode_n_o(cathode_n_o), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o));

// ---- tb/kmsd_keypad.sv ----
`timescale 1ns/1ps
module kmsd_keypad (
    input wire logic [7:0] cathode_n_i,
    input wire logic [31:0] keys_i,
    output logic [3:0] key_n_o
);
// ----
// Pulled-up return lines
// ----
always_comb begin
    for (int l = 0; l < 4; l++) begin
        key_n_o[l] = ~|(keys_i[l*8 +: 8] & ~cathode_n_i);
    end
end
endmodule

// ---- tb/kmsd_key_scan_tb.sv ----
`timescale 1ns/1ps
module kmsd_key_scan_tb;
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic [31:0] keys = 32'h0;
logic scan_en = 1'b1;
logic [3:0] key_n;
kmsd_pkg::kmsd_req_s req = '0;
logic [7:0] rdata;
logic [7:0] cath_n;
logic rvalid;
logic irq_n;
int fail_count = 0;
int samples_checked = 0;
always #2.5 clk_i = ~clk_i;
kmsd_key_scan #(.SLOT_CYC(8)) kmsd_key_scan_inst (.clk_i(clk_i), .rst_i(rst_i), .scan_en_i(scan_en),
    .scan_limit_i(3'h6), .line_en_i(4'hf), .key_n_i(key_n), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .cathode_n_o(cath_n), .irq_n_o(irq_n), .irq_oe_o());
kmsd_keypad kmsd_keypad_inst (.cathode_n_i(cath_n), .keys_i(keys), .key_n_o(key_n));
// ----
// Tasks
// ----
task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        fail_count++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req <= '{1'b1, 1'b0, a, d};
    @(negedge clk_i);
    req <= '0;
endtask
task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i);
    req <= '0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
endtask
task irq(input logic exp);
    @(negedge clk_i);
    chk({7'h00, irq_n}, {7'h00, exp});
endtask
// Two full passes of 7 multiplex cycles of 56 clocks each, plus input sync
task wt;
    repeat (900) @(negedge clk_i);
endtask
task end_sim;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
// ----
// Sequence
// ----
initial begin
    repeat (16) @(negedge clk_i);
    rst_i <= 1'b0;
    for (int a = 8; a < 16; a++)
        rd(a[7:0], 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h00);
    wr(8'h08, 8'h01);
    keys <= 32'h0000_0281;
    wt;
    irq(1'b0);
    rd(8'h0c, 8'h01);
    rd(8'h0d, 8'h02);
    irq(1'b0);
    rd(8'h08, 8'h01);
    irq(1'b1);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h02);
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    wt;
    rd(8'h08, 8'h00);
    irq(1'b1);
    wr(8'h08, 8'h00);
    keys <= 32'h0;
    wt;
    rd(8'h0c, 8'h00);
    keys <= 32'h1;
    wt;
    keys <= 32'h2;
    wt;
    irq(1'b1);
    rd(8'h08, 8'h03);
    scan_en <= 1'b0;
    keys <= 32'h4;
    wt;
    rd(8'h0c, 8'h02);
    rd(8'h08, 8'h00);
    end_sim;
end
initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    end_sim;
end
endmodule
